//--- logic/ettc_consts.svh
`ifndef ETTC_CONSTS_SVH
`define ETTC_CONSTS_SVH
// Function
// R01 - Three register stages on every user I/O
// R02 - Simplex generator waits for external alignment
// R03 - Lane switch pulse launches reconfiguration writes
// R04 - Rerun sanity test after reconfiguration
// R05 - User sends one switch pulse per alignment
// R06 - Restart acts only when both idle
// R07 - Generator busy blocks restart
// R08 - Monitor busy blocks restart
// R09 - Lane mode indicator: 0 ten, 1 four
// R10 - Transmit done after all packets sent
// R11 - Receive done after all packets received
// R12 - Data failure on payload mismatch
// R13 - Receive aligned follows core alignment
// R14 - Lock indicators follow transceiver lock
// R15 - Statistics tick governs statistics reads
// R16 - Generator and monitor wait for link
// R17 - Completion pulse resets the transceiver
// R18 - Accepted restart clears done and failure

// Register byte offsets
`define ETTC_ADDR_CTRL 8'h00
`define ETTC_ADDR_STATUS 8'h04
`define ETTC_ADDR_IRQ_STAT 8'h08
`define ETTC_ADDR_IRQ_MASK 8'h0C
`define ETTC_ADDR_PKT_TARGET 8'h10
`define ETTC_ADDR_TX_SNAP 8'h14
`define ETTC_ADDR_RX_SNAP 8'h18

// Control register fields
`define ETTC_CTRL_SIMPLEX 0
`define ETTC_CTRL_SWITCHABLE 1
`define ETTC_CTRL_RESTART 2
`define ETTC_CTRL_STATS_EN 3
`define ETTC_CTRL_RST 4'h0

// Interrupt bit positions
`define ETTC_IRQ_TX_DONE 0
`define ETTC_IRQ_RX_DONE 1
`define ETTC_IRQ_FAIL 2
`define ETTC_IRQ_RECONFIG 3
`define ETTC_IRQ_SNAP 4
`define ETTC_IRQ_W 5

// Packet count and payload pattern
`define ETTC_PKT_TARGET_RST 16'h0040
`define ETTC_DATA_SEED 32'hA5A50000

// Reconfiguration write sequence
`define ETTC_RC_WRITES 3'h4
`define ETTC_RC_ADDR_BASE 10'h000
`define ETTC_RC_DATA_TEN 16'h0000
`define ETTC_RC_DATA_FOUR 16'h0001

// Transceiver reset pulse after reconfiguration, least time
`define ETTC_CLK_MHZ 250
`define ETTC_SRST_NS 100
`define ETTC_SRST_CYC ((`ETTC_SRST_NS * `ETTC_CLK_MHZ + 999) / 1000)
`endif

//--- logic/ettc_pkg.sv
package ettc_pkg;
  // Generator and monitor run states
  typedef enum logic [1:0] {
    RUN_IDLE = 2'h0,
    RUN_WAIT = 2'h1,
    RUN_ACTIVE = 2'h2,
    RUN_DONE = 2'h3
  } ettc_run_t;
  // Reconfiguration sequencer states
  typedef enum logic [1:0] {
    RC_IDLE = 2'h0,
    RC_WRITE = 2'h1,
    RC_WAIT = 2'h2,
    RC_RESET = 2'h3
  } ettc_rc_t;
endpackage : ettc_pkg

//--- logic/ettc_sync3.sv
// Three cascaded flops per bit; only the last stage is read outside
module ettc_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_r; // First stage, read only by the second
      logic s2_r; // Second stage
      logic s3_r; // Third stage, drives q
      // Three-stage chain
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
        end else begin
          s1_r <= d[i]; // R01
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      assign q[i] = s3_r;
    end
  endgenerate
endmodule : ettc_sync3

//--- logic/ettc_top.sv
// The address-and-strobe port and the address map were decided locally.
`include "ettc_consts.svh"

module ettc_top
  import ettc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic restart_in,
  input wire logic lane_switch_in,
  input wire logic simplex_rx_aligned,
  input wire logic stats_snapshot_tick,
  input wire logic serdes_tx_locked,
  input wire logic serdes_rx_locked,
  input wire logic core_rx_aligned,
  input wire logic tx_ready,
  output logic tx_pkt_valid,
  output logic [31:0] tx_pkt_data,
  input wire logic rx_pkt_valid,
  input wire logic [31:0] rx_pkt_data,
  output logic [9:0] reconfig_addr,
  output logic [15:0] reconfig_wdata,
  output logic reconfig_we,
  input wire logic reconfig_ack,
  output logic reconfig_writes_complete,
  output logic serdes_reset,
  output logic xmit_serdes_lock_ind,
  output logic recv_serdes_lock_ind,
  output logic rx_aligned_ind,
  output logic tx_busy_ind,
  output logic rx_busy_ind,
  output logic tx_done_ind,
  output logic rx_done_ind,
  output logic data_fail_ind,
  output logic lane_mode_ind
);

  localparam logic [4:0] SRST_CYC = 5'(`ETTC_SRST_CYC);

  // Synchronised pin inputs
  logic [6:0] in_s;
  logic restart_s; // Pushbutton restart
  logic switch_s; // Lane switch pulse
  logic simplex_al_s; // External simplex receiver aligned
  logic tick_s; // Statistics tick
  logic tx_lock_s; // Transmit serdes lock
  logic rx_lock_s; // Receive serdes lock
  logic aligned_s; // Core receive alignment

  // Registers and state
  logic [3:0] ctrl_r; // Software control bits
  logic [15:0] pkt_target_r; // Packets per run
  logic [`ETTC_IRQ_W-1:0] irq_stat_r; // Sticky events
  logic [`ETTC_IRQ_W-1:0] irq_mask_r; // Interrupt enables
  logic [15:0] tx_snap_r; // Sent count at last tick
  logic [15:0] rx_snap_r; // Received count at last tick
  logic restart_d_r; // Edge detect history
  logic switch_d_r;
  logic tick_d_r;
  ettc_run_t gen_r; // Generator state
  ettc_run_t mon_r; // Monitor state
  ettc_rc_t rc_r; // Reconfiguration state
  logic [15:0] tx_cnt_r; // Packets sent
  logic [15:0] rx_cnt_r; // Packets received
  logic fail_r; // Payload mismatch seen
  logic lane_four_r; // 0 ten-lane, 1 four-lane
  logic [2:0] rc_idx_r; // Write index in sequence
  logic [4:0] srst_cnt_r; // Transceiver reset length
  logic rc_done_r; // Completion pulse
  logic [31:0] rdata_r; // Read data, one cycle after strobe
  logic tx_valid_r;
  logic [31:0] tx_data_r;

  // Derived terms
  logic restart_rise;
  logic switch_rise;
  logic tick_rise;
  logic sw_restart;
  logic link_up;
  logic gen_go;
  logic gen_busy;
  logic mon_busy;
  logic restart_ok;
  logic rc_finish;
  logic [`ETTC_IRQ_W-1:0] irq_evt;
  logic [31:0] expect_data;
  logic tx_beat;

  // Pin inputs through three stages before use
  ettc_sync3 #(
    .WIDTH(7)
  ) u_in_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .d({restart_in, lane_switch_in, simplex_rx_aligned,
        stats_snapshot_tick, serdes_tx_locked, serdes_rx_locked,
        core_rx_aligned}), // R01
    .q(in_s)
  );
  assign {restart_s, switch_s, simplex_al_s, tick_s,
          tx_lock_s, rx_lock_s, aligned_s} = in_s;

  // Edge history of pulse inputs
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      restart_d_r <= 1'b0;
      switch_d_r <= 1'b0;
      tick_d_r <= 1'b0;
    end else begin
      restart_d_r <= restart_s;
      switch_d_r <= switch_s;
      tick_d_r <= tick_s;
    end
  end

  assign restart_rise = restart_s & ~restart_d_r;
  assign switch_rise = switch_s & ~switch_d_r;
  assign tick_rise = tick_s & ~tick_d_r;
  assign sw_restart = reg_wr && (reg_addr == `ETTC_ADDR_CTRL) &&
                      reg_wdata[`ETTC_CTRL_RESTART];

  // Link ready; simplex also needs the remote receiver aligned
  assign link_up = tx_lock_s & rx_lock_s & aligned_s; // R16
  assign gen_go = link_up &
                  (~ctrl_r[`ETTC_CTRL_SIMPLEX] | simplex_al_s); // R02

  // Busy while waiting or running
  assign gen_busy = (gen_r == RUN_WAIT) || (gen_r == RUN_ACTIVE); // R07
  assign mon_busy = (mon_r == RUN_WAIT) || (mon_r == RUN_ACTIVE); // R08
  // Restart only with both ends idle and no switch under way
  assign restart_ok = (restart_rise | sw_restart) & ~gen_busy &
                      ~mon_busy & (rc_r == RC_IDLE); // R06
  assign rc_finish = (rc_r == RC_RESET) && (srst_cnt_r == 5'h00);

  assign tx_beat = tx_valid_r & tx_ready;
  assign expect_data = `ETTC_DATA_SEED ^ {16'h0000, rx_cnt_r};

  // Generator state machine
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gen_r <= RUN_WAIT;
    end else if (rc_r != RC_IDLE) begin
      // Held during reconfiguration, rerun once finished
      gen_r <= rc_finish ? RUN_WAIT : RUN_IDLE; // R04
    end else begin
      unique case (gen_r)
        RUN_IDLE, RUN_DONE: begin
          if (restart_ok) begin
            gen_r <= RUN_WAIT; // R06
          end
        end
        RUN_WAIT: begin
          if (gen_go) begin
            gen_r <= RUN_ACTIVE; // R16
          end
        end
        RUN_ACTIVE: begin
          // Last packet accepted by the core
          if (tx_beat && (tx_cnt_r == pkt_target_r - 16'h0001)) begin
            gen_r <= RUN_DONE; // R10
          end
        end
      endcase
    end
  end

  // Generator count and output word
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_cnt_r <= 16'h0000;
      tx_valid_r <= 1'b0;
      tx_data_r <= 32'h00000000;
    end else if (gen_r != RUN_ACTIVE) begin
      // Valid dropped while not sending; count and word reset in RUN_WAIT so a rerun starts fresh
      tx_valid_r <= 1'b0;
      if (gen_r == RUN_WAIT) begin
        tx_cnt_r <= 16'h0000; // R18
        tx_data_r <= `ETTC_DATA_SEED;
      end
    end else if (tx_beat) begin
      tx_cnt_r <= tx_cnt_r + 16'h0001;
      tx_data_r <= `ETTC_DATA_SEED ^ {16'h0000, tx_cnt_r + 16'h0001};
      tx_valid_r <= (tx_cnt_r != pkt_target_r - 16'h0001);
    end else begin
      tx_valid_r <= 1'b1;
    end
  end

  assign tx_pkt_valid = tx_valid_r;
  assign tx_pkt_data = tx_data_r;

  // Monitor state machine
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mon_r <= RUN_WAIT;
    end else if (rc_r != RC_IDLE) begin
      mon_r <= rc_finish ? RUN_WAIT : RUN_IDLE; // R04
    end else begin
      unique case (mon_r)
        RUN_IDLE, RUN_DONE: begin
          if (restart_ok) begin
            mon_r <= RUN_WAIT; // R06
          end
        end
        RUN_WAIT: begin
          if (link_up) begin
            mon_r <= RUN_ACTIVE; // R16
          end
        end
        RUN_ACTIVE: begin
          if (rx_pkt_valid && (rx_cnt_r == pkt_target_r - 16'h0001)) begin
            mon_r <= RUN_DONE; // R11
          end
        end
      endcase
    end
  end

  // Monitor count and payload compare
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rx_cnt_r <= 16'h0000;
      fail_r <= 1'b0;
    end else if (mon_r == RUN_WAIT) begin
      // Fresh run clears the old result
      rx_cnt_r <= 16'h0000; // R18
      fail_r <= 1'b0; // R18
    end else if (mon_r == RUN_ACTIVE && rx_pkt_valid) begin
      rx_cnt_r <= rx_cnt_r + 16'h0001;
      if (rx_pkt_data != expect_data) begin
        fail_r <= 1'b1; // R12
      end
    end
  end

  // Reconfiguration sequencer
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rc_r <= RC_IDLE;
      rc_idx_r <= 3'h0;
      srst_cnt_r <= 5'h00;
      lane_four_r <= 1'b0;
      rc_done_r <= 1'b0;
    end else begin
      rc_done_r <= 1'b0;
      unique case (rc_r)
        RC_IDLE: begin
          // Further pulses ignored until the sequence ends
          if (switch_rise && ctrl_r[`ETTC_CTRL_SWITCHABLE]) begin
            rc_r <= RC_WRITE; // R03
            rc_idx_r <= 3'h0;
          end
        end
        RC_WRITE: begin
          rc_r <= RC_WAIT;
        end
        RC_WAIT: begin
          if (reconfig_ack) begin
            if (rc_idx_r == `ETTC_RC_WRITES - 3'h1) begin
              rc_r <= RC_RESET;
              srst_cnt_r <= SRST_CYC - 5'h01;
              lane_four_r <= ~lane_four_r; // R09
              rc_done_r <= 1'b1; // R17
            end else begin
              rc_idx_r <= rc_idx_r + 3'h1;
              rc_r <= RC_WRITE; // R03
            end
          end
        end
        RC_RESET: begin
          // Transceiver held in reset, then test reruns
          if (srst_cnt_r == 5'h00) begin
            rc_r <= RC_IDLE; // R04
          end else begin
            srst_cnt_r <= srst_cnt_r - 5'h01;
          end
        end
      endcase
    end
  end

  // One write per index, data selects the target lane mode
  assign reconfig_we = (rc_r == RC_WRITE); // R03
  assign reconfig_addr = `ETTC_RC_ADDR_BASE + {7'h00, rc_idx_r};
  assign reconfig_wdata = lane_four_r ? `ETTC_RC_DATA_TEN :
                          `ETTC_RC_DATA_FOUR;
  assign reconfig_writes_complete = rc_done_r; // R17
  assign serdes_reset = (rc_r == RC_RESET); // R17

  // Control registers written by software
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= `ETTC_CTRL_RST;
      pkt_target_r <= `ETTC_PKT_TARGET_RST;
      irq_mask_r <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `ETTC_ADDR_CTRL: begin
          // Restart bit is a strobe, not stored
          ctrl_r <= reg_wdata[3:0] & 4'hB;
        end
        `ETTC_ADDR_IRQ_MASK: begin
          irq_mask_r <= reg_wdata[`ETTC_IRQ_W-1:0];
        end
        `ETTC_ADDR_PKT_TARGET: begin
          // Zero would never finish, so keep at least one
          pkt_target_r <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001 :
                          reg_wdata[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Statistics snapshot on the tick when enabled
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_snap_r <= 16'h0000;
      rx_snap_r <= 16'h0000;
    end else if (tick_rise && ctrl_r[`ETTC_CTRL_STATS_EN]) begin
      tx_snap_r <= tx_cnt_r; // R15
      rx_snap_r <= rx_cnt_r; // R15
    end
  end

  // Events: done and fail edges, reconfig end, snapshot
  assign irq_evt[`ETTC_IRQ_TX_DONE] = gen_r == RUN_ACTIVE && tx_beat &&
                                      tx_cnt_r == pkt_target_r - 16'h0001;
  assign irq_evt[`ETTC_IRQ_RX_DONE] = mon_r == RUN_ACTIVE && rx_pkt_valid &&
                                      rx_cnt_r == pkt_target_r - 16'h0001;
  assign irq_evt[`ETTC_IRQ_FAIL] = mon_r == RUN_ACTIVE && rx_pkt_valid &&
                                   rx_pkt_data != expect_data && ~fail_r;
  assign irq_evt[`ETTC_IRQ_RECONFIG] = rc_done_r;
  assign irq_evt[`ETTC_IRQ_SNAP] = tick_rise & ctrl_r[`ETTC_CTRL_STATS_EN];

  // Sticky status, write one to clear; a new event wins
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_stat_r <= '0;
    end else begin
      if (reg_wr && reg_addr == `ETTC_ADDR_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~reg_wdata[`ETTC_IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ETTC_ADDR_CTRL: rdata_r <= {28'h0000000, ctrl_r};
        `ETTC_ADDR_STATUS: begin
          rdata_r <= {21'h000000, lane_four_r, rc_r, mon_r, gen_r,
                      fail_r, aligned_s, rx_lock_s, tx_lock_s};
        end
        `ETTC_ADDR_IRQ_STAT: rdata_r <= {27'h0000000, irq_stat_r};
        `ETTC_ADDR_IRQ_MASK: rdata_r <= {27'h0000000, irq_mask_r};
        `ETTC_ADDR_PKT_TARGET: rdata_r <= {16'h0000, pkt_target_r};
        `ETTC_ADDR_TX_SNAP: rdata_r <= {16'h0000, tx_snap_r};
        `ETTC_ADDR_RX_SNAP: rdata_r <= {16'h0000, rx_snap_r};
        // Unmapped offsets read zero
        default: rdata_r <= 32'h00000000;
      endcase
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

  assign reg_rdata = rdata_r;

  // Status indicators through three stages to the pins
  ettc_sync3 #(
    .WIDTH(9)
  ) u_out_pipe (
    .ref_clk(ref_clk),
    .reset(reset),
    .d({tx_lock_s, // R14
        rx_lock_s, // R14
        aligned_s, // R13
        gen_busy, // R07
        mon_busy, // R08
        gen_r == RUN_DONE, // R10
        mon_r == RUN_DONE, // R11
        fail_r, // R12
        lane_four_r}), // R09
    .q({xmit_serdes_lock_ind, recv_serdes_lock_ind, rx_aligned_ind,
        tx_busy_ind, rx_busy_ind, tx_done_ind, rx_done_ind,
        data_fail_ind, lane_mode_ind}) // R01
  );

endmodule : ettc_top

//--- verification/ettc_props.sv
// Port-level checks of the reconfiguration, transmit and indicator paths
module ettc_props (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [9:0] reconfig_addr,
  input wire logic [15:0] reconfig_wdata,
  input wire logic reconfig_we,
  input wire logic reconfig_ack,
  input wire logic reconfig_writes_complete,
  input wire logic serdes_reset,
  input wire logic tx_ready,
  input wire logic tx_pkt_valid,
  input wire logic [31:0] tx_pkt_data,
  input wire logic tx_busy_ind,
  input wire logic rx_busy_ind,
  input wire logic tx_done_ind,
  input wire logic rx_done_ind,
  input wire logic lane_mode_ind
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [5:0] srst_len_r; // Length of the running transceiver reset
  logic lane_prev_r; // Lane indicator as it stood at completion
  // Count cycles of transceiver reset, cleared when it drops
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) srst_len_r <= 6'h00;
    else if (serdes_reset) srst_len_r <= srst_len_r + 6'h01;
    else srst_len_r <= 6'h00;
  end
  // Remember the indicator so a missed toggle shows up later
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) lane_prev_r <= 1'b0;
    else if (reconfig_writes_complete) lane_prev_r <= lane_mode_ind;
  end
  // One write step: strobe for one cycle, then low in the next
  sequence s_write_step;
    reconfig_we ##1 !reconfig_we;
  endsequence
  sequence s_step_done;
    reconfig_ack;
  endsequence
  chk_we_pulse: assert property (reconfig_we |-> s_write_step)
    else $error("reconfig strobe longer than one cycle");
  chk_req_hold: assert property (reconfig_we |=>
    $stable(reconfig_addr) && $stable(reconfig_wdata))
    else $error("reconfig request changed before ack");
  chk_next_step: assert property (s_step_done |->
    ##[1:3] (reconfig_we || reconfig_writes_complete))
    else $error("no next reconfig step after ack");
  chk_cmpl_pulse: assert property (reconfig_writes_complete |=>
    !reconfig_writes_complete)
    else $error("completion not a single pulse");
  chk_srst_start: assert property (reconfig_writes_complete |->
    ##[0:2] serdes_reset)
    else $error("transceiver reset did not follow completion");
  chk_srst_len: assert property ($fell(serdes_reset) |->
    srst_len_r == 6'h19)
    else $error("transceiver reset length wrong");
  chk_lane_flip: assert property (reconfig_writes_complete |=>
    ##[0:6] (lane_mode_ind != lane_prev_r))
    else $error("lane indicator did not toggle");
  chk_tx_hold: assert property (tx_pkt_valid && !tx_ready |=>
    tx_pkt_valid && $stable(tx_pkt_data))
    else $error("tx word dropped under stall");
  chk_tx_excl: assert property (tx_done_ind |-> !tx_busy_ind)
    else $error("generator busy and done together");
  chk_rx_excl: assert property (rx_done_ind |-> !rx_busy_ind)
    else $error("monitor busy and done together");
endmodule : ettc_props

bind ettc_top ettc_props ettc_props_i (.ref_clk(ref_clk), .reset(reset),
  .reconfig_addr(reconfig_addr), .reconfig_wdata(reconfig_wdata),
  .reconfig_we(reconfig_we), .reconfig_ack(reconfig_ack),
  .reconfig_writes_complete(reconfig_writes_complete),
  .serdes_reset(serdes_reset), .tx_ready(tx_ready),
  .tx_pkt_valid(tx_pkt_valid), .tx_pkt_data(tx_pkt_data),
  .tx_busy_ind(tx_busy_ind), .rx_busy_ind(rx_busy_ind),
  .tx_done_ind(tx_done_ind), .rx_done_ind(rx_done_ind),
  .lane_mode_ind(lane_mode_ind));

//--- verification/ettc_core_model.sv
// Core and transceiver stand-in: loops words back, acks writes
module ettc_core_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic link_up, // Bench: link may come up
  input wire logic slow, // Bench: stall traffic, late acks
  input wire logic corrupt, // Bench: damage looped words
  input wire logic serdes_reset,
  input wire logic tx_pkt_valid,
  input wire logic [31:0] tx_pkt_data,
  input wire logic reconfig_we,
  output logic serdes_tx_locked,
  output logic serdes_rx_locked,
  output logic core_rx_aligned,
  output logic tx_ready,
  output logic rx_pkt_valid,
  output logic [31:0] rx_pkt_data,
  output logic reconfig_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph_r; // Stall phase, ready every other cycle when slow
  logic [2:0] ack_cnt_r; // Cycles until the pending write is acked
  // Lock is lost while the transceiver is held in reset
  assign serdes_tx_locked = link_up && !serdes_reset;
  assign serdes_rx_locked = link_up && !serdes_reset;
  assign core_rx_aligned = link_up && !serdes_reset;
  assign tx_ready = !slow || ph_r;
  // Loopback; idle data inverted so stale words never look valid
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ph_r <= 1'b0;
      rx_pkt_valid <= 1'b0;
      rx_pkt_data <= 32'h0;
    end else begin
      ph_r <= !ph_r;
      rx_pkt_valid <= tx_pkt_valid && tx_ready;
      if (tx_pkt_valid && tx_ready) begin
        rx_pkt_data <= tx_pkt_data ^ {31'h0, corrupt};
      end else begin
        rx_pkt_data <= ~rx_pkt_data;
      end
    end
  end
  // Write ack after one or five cycles
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ack_cnt_r <= 3'h0;
      reconfig_ack <= 1'b0;
    end else begin
      if (reconfig_we) ack_cnt_r <= slow ? 3'h5 : 3'h1;
      else if (ack_cnt_r != 3'h0) ack_cnt_r <= ack_cnt_r - 3'h1;
      reconfig_ack <= !reconfig_we && ack_cnt_r == 3'h1;
    end
  end
endmodule : ettc_core_model

//--- verification/ettc_tb_top.sv
`include "ettc_consts.svh"
module ettc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] e;
  } ettc_row_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic restart_in = 1'b0, lane_switch_in = 1'b0;
  logic simplex_rx_aligned = 1'b0, stats_snapshot_tick = 1'b0;
  logic link_up = 1'b0, slow = 1'b1, corrupt = 1'b0;
  logic serdes_tx_locked, serdes_rx_locked, core_rx_aligned, tx_ready;
  logic rx_pkt_valid, reconfig_ack, irq, tx_pkt_valid, reconfig_we;
  logic [31:0] rx_pkt_data, tx_pkt_data, reg_rdata;
  logic [9:0] reconfig_addr;
  logic [15:0] reconfig_wdata, exp_mode;
  logic reconfig_writes_complete, serdes_reset, xmit_serdes_lock_ind;
  logic recv_serdes_lock_ind, rx_aligned_ind, tx_busy_ind, rx_busy_ind;
  logic tx_done_ind, rx_done_ind, data_fail_ind, lane_mode_ind;
  logic [10:0] ind; // All indicators in one vector for waits
  int failures = 0, n_compared = 0, beat_k = 0, n_we = 0;
  assign ind = {serdes_reset, reconfig_writes_complete, lane_mode_ind,
    data_fail_ind, rx_done_ind, tx_done_ind, rx_busy_ind, tx_busy_ind,
    rx_aligned_ind, recv_serdes_lock_ind, xmit_serdes_lock_ind};
  always #2 ref_clk = ~ref_clk;
  ettc_top ettc_top_i (.*);
  ettc_core_model ettc_core_model_i (.*);
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : reg_wr_t
  // Data stand only in the cycle after the strobe
  task automatic reg_rd_t(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_rd_t
  // One-cycle pulses on {tick, lane switch, restart}
  task automatic pulse_in(input logic [2:0] m);
    @(posedge ref_clk);
    {stats_snapshot_tick, lane_switch_in, restart_in} <= m;
    @(posedge ref_clk);
    {stats_snapshot_tick, lane_switch_in, restart_in} <= 3'h0;
  endtask : pulse_in
  // Bounded wait on one indicator, then compare
  task automatic wait_bit(input int b, input logic v, input int lim,
                          input string nm);
    int i;
    i = 0;
    while (ind[b] !== v && i < lim) begin
      @(posedge ref_clk);
      #1 i++;
    end
    chk(nm, {31'h0, v}, {31'h0, ind[b]});
  endtask : wait_bit
  // Every accepted word carries the running pattern
  always @(posedge ref_clk) begin
    if (tx_pkt_valid === 1'b1 && tx_ready === 1'b1) begin
      chk("tx_data", `ETTC_DATA_SEED ^ 32'(beat_k), tx_pkt_data);
      beat_k++;
    end
  end
  // Each reconfig write: address steps 0..3, data names the new mode
  always @(posedge ref_clk) begin
    if (reconfig_we === 1'b1) begin
      chk("rc_addr", 32'(n_we), {22'h0, reconfig_addr});
      chk("rc_data", {16'h0, exp_mode}, {16'h0, reconfig_wdata});
      n_we++;
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    finish_test;
  end
  initial begin
    ettc_row_t rows [11];
    logic [31:0] rd;
    rows = '{'{8'h00, 1'b0, 32'h0, 32'h0}, '{8'h04, 1'b0, 32'h0, 32'h50},
      '{8'h08, 1'b0, 32'h0, 32'h0}, '{8'h0C, 1'b0, 32'h0, 32'h0},
      '{8'h10, 1'b0, 32'h0, 32'h40}, '{8'h1C, 1'b0, 32'h0, 32'h0},
      '{8'h10, 1'b1, 32'h0, 32'h1}, '{8'h10, 1'b1, 32'h8, 32'h8},
      '{8'h0C, 1'b1, 32'h1F, 32'h1F}, '{8'h1C, 1'b1, 32'hF, 32'h0},
      '{8'h00, 1'b1, 32'hA, 32'hA}};
    repeat (10) @(posedge ref_clk);
    chk("ind_reset", 32'h0, {21'h0, ind});
    reset <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) reg_wr_t(rows[i].a, rows[i].d);
      reg_rd_t(rows[i].a, rd);
      chk("reg", rows[i].e, rd);
    end
    @(posedge ref_clk);
    link_up <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk("lock_early", 32'h0, {29'h0, ind[2:0]});
    wait_bit(0, 1'b1, 20, "xlock");
    wait_bit(1, 1'b1, 20, "rlock");
    wait_bit(2, 1'b1, 20, "aligned");
    wait_bit(5, 1'b1, 300, "tx_done");
    wait_bit(6, 1'b1, 300, "rx_done");
    chk("beats", 32'h8, 32'(beat_k));
    chk("no_fail", 32'h0, {31'h0, data_fail_ind});
    reg_rd_t(8'h08, rd);
    chk("irq_stat", 32'h3, rd);
    reg_wr_t(8'h08, 32'h1);
    reg_rd_t(8'h08, rd);
    chk("w1c", 32'h2, rd);
    reg_wr_t(8'h0C, 32'h0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    reg_wr_t(8'h0C, 32'h1F);
    chk("irq_on", 32'h1, {31'h0, irq});
    reg_wr_t(8'h08, 32'h2);
    chk("irq_clear", 32'h0, {31'h0, irq});
    reg_wr_t(8'h10, 32'h40);
    beat_k = 0;
    pulse_in(3'h1);
    wait_bit(3, 1'b1, 30, "tx_busy");
    chk("done_clr", 32'h0, {30'h0, ind[6:5]});
    repeat (20) @(posedge ref_clk);
    corrupt <= 1'b1;
    repeat (2) @(posedge ref_clk);
    corrupt <= 1'b0;
    wait_bit(7, 1'b1, 40, "fail");
    chk("busy_on", 32'h3, {30'h0, ind[4:3]});
    pulse_in(3'h1);
    repeat (12) @(posedge ref_clk);
    #1 chk("refused", 32'h1, {31'h0, data_fail_ind});
    wait_bit(6, 1'b1, 400, "rx_done2");
    chk("beats2", 32'h40, 32'(beat_k));
    beat_k = 0;
    reg_wr_t(8'h00, 32'hE);
    wait_bit(7, 1'b0, 20, "fail_clr");
    wait_bit(6, 1'b1, 400, "rx_done3");
    chk("no_fail2", 32'h0, {31'h0, data_fail_ind});
    for (int i = 0; i < 2; i++) begin
      exp_mode = {15'h0, i == 0};
      n_we = 0;
      wait_bit(2, 1'b1, 60, "aligned_again");
      pulse_in(3'h2);
      slow <= (i == 1);
      beat_k = 0;
      wait_bit(9, 1'b1, 200, "rc_done");
      chk("we_count", 32'h4, 32'(n_we));
      wait_bit(10, 1'b1, 4, "srst");
      wait_bit(8, i == 0, 10, "lane_ind");
      wait_bit(3, 1'b1, 80, "rerun_busy");
      wait_bit(6, 1'b1, 400, "rerun_done");
      chk("rerun_beats", 32'h40, 32'(beat_k));
    end
    pulse_in(3'h4);
    repeat (8) @(posedge ref_clk);
    reg_rd_t(8'h08, rd);
    chk("snap_irq", 32'h1F, rd);
    reg_rd_t(8'h14, rd);
    chk("snap", 32'h40, rd);
    reg_wr_t(8'h00, 32'hB);
    beat_k = 0;
    reg_wr_t(8'h00, 32'hF);
    repeat (40) @(posedge ref_clk);
    chk("simplex_hold", 32'h0, 32'(beat_k));
    simplex_rx_aligned <= 1'b1;
    wait_bit(5, 1'b1, 400, "simplex_done");
    finish_test;
  end
endmodule : ettc_tb_top
